// ### hdl/pss_seq.sv
`timescale 1ns/1ps
module pss_seq
	import pss_pkg::*;
#(
	parameter int MS_CYC = pss_pkg::MS_CYCLES
)
(
	// Clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          sys_rst,
	// Register port
	input  wire logic [pss_pkg::ADDR_W-1:0]    reg_addr,
	input  wire logic [pss_pkg::DATA_W-1:0]    reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [pss_pkg::DATA_W-1:0]    reg_rdata,
	// System control pins
	input  wire logic                          main_on_request_n,
	input  wire logic                          hot_unplug_kill,
	output logic                               input_good,
	output logic                               outputs_good,
	output logic                               fault_alert_n,
	output logic                               present_n,
	// Power train status
	input  wire logic                          input_in_range,
	input  wire logic                          main_in_regulation,
	input  wire logic                          standby_in_regulation,
	input  wire logic                          standby_trip,
	output logic                               main_output_en,
	output logic                               standby_output_en,
	// Shutdown events
	input  wire logic                          over_current_trip,
	input  wire logic                          over_voltage_trip,
	input  wire logic                          under_voltage_trip,
	input  wire logic                          over_temp_trip,
	input  wire logic                          fan_fail,
	input  wire logic                          general_failure,
	// Warning events and temperature
	input  wire logic [pss_pkg::TEMP_W-1:0]    inlet_temp,
	input  wire logic                          hotspot_temp_warn,
	input  wire logic                          high_current_warn,
	input  wire logic                          fan_slow_warn,
	input  wire logic                          fan_at_full,
	output logic                               fan_full_cmd,
	// Load share
	input  wire logic                          share_is_master,
	input  wire logic [pss_pkg::TRIM_W-1:0]    share_trim_req_mv,
	output logic                               load_share_connect,
	output logic      [pss_pkg::TRIM_W-1:0]    share_trim_mv,
	// Status lamp
	output logic                               led_green,
	output logic                               led_amber
);
	import pss_pkg::*;

	function automatic logic reached(input logic [CNT_W-1:0] cnt,
	                                 input logic [CNT_W-1:0] lim);
		reached = (cnt >= lim);
	endfunction : reached

	// Millisecond prescaler
	logic [PRE_W-1:0] pre_r;
	logic             ms_tick;
	wire              pre_wrap = (pre_r == PRE_W'(MS_CYC - 1));

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			pre_r   <= '0;
			ms_tick <= 1'b0;
		end
		else
		begin
			pre_r   <= pre_wrap ? '0 : pre_r + PRE_W'(1);
			ms_tick <= pre_wrap;
		end
	end

	// Control register
	logic [1:0] ctrl_r;
	wire        fw_upload   = ctrl_r[CTRL_FW_UPLOAD];
	wire        reverse_air = ctrl_r[CTRL_REVERSE];
	wire        ctrl_wr     = reg_wr && (reg_addr == REG_CTRL);

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			ctrl_r <= CTRL_RST;
		else if (ctrl_wr)
			ctrl_r <= reg_wdata[1:0];
	end

	// On request edge clears latched faults
	logic req_prev_r;
	wire  req_active = !main_on_request_n;
	wire  fault_clr  = req_active && !req_prev_r;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			req_prev_r <= 1'b0;
		else
			req_prev_r <= req_active;
	end

	// Shutdown latches, new event wins over clear
	logic [NUM_SD-1:0] sd_lat_r;
	wire  [NUM_SD-1:0] sd_in = {general_failure, fan_fail, over_temp_trip,
	                            under_voltage_trip, over_voltage_trip, over_current_trip};
	wire               shutdown = |sd_lat_r;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SD; gi++)
		begin : g_sd
			always_ff @(posedge sys_clk)
			begin
				if (sys_rst)
					sd_lat_r[gi] <= 1'b0;
				else
					sd_lat_r[gi] <= sd_in[gi] || (sd_lat_r[gi] && !fault_clr);
			end
		end
	endgenerate

	// Inlet warning, cleared when back in range
	wire [TEMP_W-1:0] temp_lim  = reverse_air ? TEMP_WARN_REVERSE : TEMP_WARN_NORMAL;
	wire              inlet_hot = (inlet_temp >= temp_lim);
	wire              temp_warn = inlet_hot || hotspot_temp_warn;
	// Fan commanded first; alert waits for full speed
	wire              temp_alert = temp_warn && fan_full_cmd && fan_at_full;
	wire [NUM_WN-1:0] wn_in = {fan_slow_warn, high_current_warn, temp_alert};
	wire              warning = |wn_in;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			fan_full_cmd <= 1'b0;
		else
			fan_full_cmd <= temp_warn;
	end

	// Input-good qualification
	logic [CNT_W-1:0] ig_cnt_r;
	logic             was_up_r;
	wire  [CNT_W-1:0] ig_lim  = was_up_r ? INGOOD_DIP_MS : INGOOD_START_MS;
	wire              ig_done = reached(ig_cnt_r, ig_lim);

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			ig_cnt_r   <= '0;
			was_up_r   <= 1'b0;
			input_good <= 1'b0;
		end
		else if (!input_in_range)
		begin
			ig_cnt_r   <= '0;
			input_good <= 1'b0;
		end
		else
		begin
			ig_cnt_r   <= ig_done ? ig_cnt_r : ig_cnt_r + CNT_W'(ms_tick);
			input_good <= ig_done;
			was_up_r   <= was_up_r || ig_done;
		end
	end

	// Standby output with minimum off time
	logic [CNT_W-1:0] sb_off_r;
	wire              sb_off_done = (sb_off_r > MIN_OFF_MS);

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			standby_output_en <= 1'b0;
			sb_off_r          <= '0;
		end
		else if (standby_output_en)
		begin
			standby_output_en <= !standby_trip && input_in_range;
			sb_off_r          <= '0;
		end
		else
		begin
			sb_off_r          <= sb_off_done ? sb_off_r : sb_off_r + CNT_W'(ms_tick);
			standby_output_en <= sb_off_done && !standby_trip && input_in_range;
		end
	end

	// Main output sequencer
	pss_main_t        st_r;
	pss_main_t        st_nxt;
	logic [CNT_W-1:0] st_cnt_r;
	logic [CNT_W-1:0] off_cnt_r;
	wire              abort    = hot_unplug_kill || shutdown;
	wire              go       = req_active && input_good && !abort;
	wire              off_done = reached(off_cnt_r, MIN_OFF_MS);

	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			MAIN_OFF:
				if (go && off_done)
					st_nxt = MAIN_WAIT;
			MAIN_WAIT:
				if (!go)
					st_nxt = MAIN_OFF;
				else if (reached(st_cnt_r, ON_DELAY_MS))
					st_nxt = MAIN_ON;
			MAIN_ON:
				if (abort)
					st_nxt = MAIN_OFF;
				else if (!go)
					st_nxt = MAIN_DROP;
			MAIN_DROP:
				if (abort || (st_cnt_r > HOLDUP_MS))
					st_nxt = MAIN_OFF;
			default:
				st_nxt = MAIN_OFF;
		endcase
	end

	wire main_on_nxt = (st_nxt == MAIN_ON) || (st_nxt == MAIN_DROP);

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			st_r           <= MAIN_OFF;
			st_cnt_r       <= '0;
			off_cnt_r      <= MIN_OFF_MS;
			main_output_en <= 1'b0;
		end
		else
		begin
			st_r           <= st_nxt;
			st_cnt_r       <= (st_nxt != st_r) ? '0 : st_cnt_r + CNT_W'(ms_tick);
			main_output_en <= main_on_nxt;
			if (main_output_en)
				off_cnt_r <= '0;
			else if (!off_done)
				off_cnt_r <= off_cnt_r + CNT_W'(ms_tick);
		end
	end

	// Power-good after main comes up in regulation
	logic [CNT_W-1:0] pg_cnt_r;
	wire              in_reg  = main_in_regulation && standby_in_regulation;
	wire              pg_arm  = (st_r == MAIN_ON) && in_reg && go;
	wire              pg_done = reached(pg_cnt_r, PG_DELAY_MS);

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			pg_cnt_r     <= '0;
			outputs_good <= 1'b0;
		end
		else if (!pg_arm)
		begin
			pg_cnt_r     <= '0;
			outputs_good <= 1'b0;
		end
		else
		begin
			pg_cnt_r     <= pg_done ? pg_cnt_r : pg_cnt_r + CNT_W'(ms_tick);
			outputs_good <= pg_done;
		end
	end

	// Load share connection and follower trim
	wire [TRIM_W-1:0] trim_clip = (share_trim_req_mv > TRIM_MAX_MV) ?
	                              TRIM_MAX_MV : share_trim_req_mv;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			load_share_connect <= 1'b0;
			share_trim_mv      <= '0;
		end
		else
		begin
			load_share_connect <= main_on_nxt && !shutdown;
			share_trim_mv      <= (share_is_master || !main_on_nxt) ? '0 : trim_clip;
		end
	end

	// Lamp pattern and alert, registered together
	pss_led_t led_mode;
	assign led_mode = shutdown        ? LED_AMBER :
	                  !input_in_range ? LED_OFF :
	                  warning         ? LED_AMBER_1HZ :
	                  fw_upload       ? LED_GREEN_2HZ :
	                  outputs_good    ? LED_GREEN :
	                                    LED_GREEN_1HZ;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			fault_alert_n <= 1'b1;
		else
			fault_alert_n <= !(shutdown || warning);
	end

	pss_led u_led (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.ms_tick   (ms_tick),
		.mode      (led_mode),
		.led_green (led_green),
		.led_amber (led_amber)
	);

	assign present_n = 1'b0;

	// Register read
	wire [DATA_W-1:0] status_w = DATA_W'({st_r, fan_full_cmd, load_share_connect,
	                                      standby_output_en, main_output_en,
	                                      input_good, outputs_good});
	wire [DATA_W-1:0] events_w = DATA_W'({wn_in, sd_lat_r});
	wire [DATA_W-1:0] rd_mux   = (reg_addr == REG_CTRL)   ? DATA_W'(ctrl_r) :
	                             (reg_addr == REG_STATUS) ? status_w :
	                             (reg_addr == REG_EVENTS) ? events_w :
	                             (reg_addr == REG_TEMP)   ? DATA_W'(inlet_temp) :
	                                                        '0;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			reg_rdata <= '0;
		else
			reg_rdata <= reg_rd ? rd_mux : '0;
	end
endmodule : pss_seq

// ### hdl/pss_pkg.sv
package pss_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRE_W         = 17;
	localparam int CNT_W         = 11;
	localparam logic [CNT_W-1:0] INGOOD_START_MS = 11'h3E8;
	localparam logic [CNT_W-1:0] INGOOD_DIP_MS   = 11'h032;
	localparam logic [CNT_W-1:0] ON_DELAY_MS     = 11'h00A;
	localparam logic [CNT_W-1:0] PG_DELAY_MS     = 11'h0C8;
	localparam logic [CNT_W-1:0] HOLDUP_MS       = 11'h007;
	localparam logic [CNT_W-1:0] MIN_OFF_MS      = 11'h1F4;
	localparam logic [CNT_W-1:0] BLINK1_HALF_MS  = 11'h1F4;
	localparam logic [CNT_W-1:0] BLINK2_HALF_MS  = 11'h0FA;
	localparam int TEMP_W = 8;
	localparam logic [TEMP_W-1:0] TEMP_WARN_NORMAL  = 8'h73;
	localparam logic [TEMP_W-1:0] TEMP_WARN_REVERSE = 8'h7C;
	localparam int TRIM_W = 9;
	localparam logic [TRIM_W-1:0] TRIM_MAX_MV = 9'h0FA;
	localparam int NUM_SD = 6;
	localparam int NUM_WN = 3;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_EVENTS = 4'h8;
	localparam logic [ADDR_W-1:0] REG_TEMP   = 4'hC;
	localparam int CTRL_FW_UPLOAD = 0;
	localparam int CTRL_REVERSE   = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	typedef enum logic [2:0] {
		LED_OFF       = 3'h0,
		LED_GREEN     = 3'h1,
		LED_GREEN_1HZ = 3'h2,
		LED_GREEN_2HZ = 3'h3,
		LED_AMBER_1HZ = 3'h4,
		LED_AMBER     = 3'h5
	} pss_led_t;
	typedef enum logic [1:0] {
		MAIN_OFF  = 2'b00,
		MAIN_WAIT = 2'b01,
		MAIN_ON   = 2'b11,
		MAIN_DROP = 2'b10
	} pss_main_t;
endpackage : pss_pkg

// ### hdl/pss_led.sv
`timescale 1ns/1ps
module pss_led
	import pss_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	// Millisecond tick and pattern
	input  wire logic                  ms_tick,
	input  wire pss_pkg::pss_led_t     mode,
	// Lamp drive
	output logic                       led_green,
	output logic                       led_amber
);
	logic [CNT_W-1:0] slow_cnt_r;
	logic [CNT_W-1:0] fast_cnt_r;
	logic             slow_ph_r;
	logic             fast_ph_r;
	wire              slow_wrap = ms_tick && (slow_cnt_r == BLINK1_HALF_MS - 11'h001);
	wire              fast_wrap = ms_tick && (fast_cnt_r == BLINK2_HALF_MS - 11'h001);
	wire              grn_nxt   = (mode == LED_GREEN) ||
	                              ((mode == LED_GREEN_1HZ) && slow_ph_r) ||
	                              ((mode == LED_GREEN_2HZ) && fast_ph_r);
	wire              amb_nxt   = (mode == LED_AMBER) ||
	                              ((mode == LED_AMBER_1HZ) && slow_ph_r);

	// Half-period phases, equal on and off time
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			slow_cnt_r <= '0;
			fast_cnt_r <= '0;
			slow_ph_r  <= 1'b0;
			fast_ph_r  <= 1'b0;
		end
		else
		begin
			slow_cnt_r <= slow_wrap ? '0 : slow_cnt_r + CNT_W'(ms_tick);
			fast_cnt_r <= fast_wrap ? '0 : fast_cnt_r + CNT_W'(ms_tick);
			slow_ph_r  <= slow_ph_r ^ slow_wrap;
			fast_ph_r  <= fast_ph_r ^ fast_wrap;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			led_green <= 1'b0;
			led_amber <= 1'b0;
		end
		else
		begin
			led_green <= grn_nxt;
			led_amber <= amb_nxt;
		end
	end
endmodule : pss_led

// ### bench/pss_seq_sva.sv
`timescale 1ns/1ps
module pss_seq_sva
	import pss_pkg::*;
#(
	parameter int MS_CYC = pss_pkg::MS_CYCLES
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Watched inputs
	input wire logic input_in_range,
	input wire logic main_in_regulation,
	input wire logic standby_in_regulation,
	input wire logic hot_unplug_kill,
	input wire logic over_current_trip,
	input wire logic over_voltage_trip,
	input wire logic under_voltage_trip,
	input wire logic over_temp_trip,
	input wire logic fan_fail,
	input wire logic general_failure,
	input wire logic high_current_warn,
	input wire logic fan_slow_warn,
	// Watched outputs
	input wire logic input_good,
	input wire logic outputs_good,
	input wire logic fault_alert_n,
	input wire logic main_output_en,
	input wire logic load_share_connect,
	input wire logic led_amber
);
	logic        main_q, good_q, was_on;
	logic [31:0] mcnt, gcnt;
	wire         trip = over_current_trip | over_voltage_trip | under_voltage_trip
		| over_temp_trip | fan_fail | general_failure;
	// Cycles since main enable or input-good last changed
	always_ff @(posedge sys_clk)
	begin
		main_q <= main_output_en;
		good_q <= input_good;
		was_on <= !sys_rst && (was_on || main_output_en);
		mcnt   <= (sys_rst || main_output_en != main_q) ? 32'h0 : mcnt + 32'h1;
		gcnt   <= (sys_rst || input_good != good_q) ? 32'h0 : gcnt + 32'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	a_trip_alert: assert property (trip |=> ##1 !fault_alert_n && led_amber)
		else $error("shutdown without alert and amber");
	a_trip_off: assert property (trip |=> ##1 !main_output_en && !load_share_connect)
		else $error("shutdown left main or share on");
	a_warn_alert: assert property (high_current_warn || fan_slow_warn |=> !fault_alert_n)
		else $error("warning without alert");
	a_share_iso: assert property (!main_output_en |-> !load_share_connect)
		else $error("share line connected with main off");
	a_kill_main: assert property (hot_unplug_kill |=> !main_output_en)
		else $error("main still on under kill");
	a_ingood_drop: assert property (!input_in_range |=> !input_good)
		else $error("input good without input");
	a_pg_reg: assert property (!(main_in_regulation && standby_in_regulation) |=> !outputs_good)
		else $error("power good out of regulation");
	a_pg_delay: assert property ($rose(outputs_good) |-> main_output_en
		&& mcnt >= 99 * MS_CYC && mcnt <= 501 * MS_CYC)
		else $error("power good delay out of window");
	a_off_time: assert property ($rose(main_output_en) && was_on |-> mcnt >= 500 * MS_CYC)
		else $error("main restarted too soon");
	a_ingood_lead: assert property ($fell(main_output_en) && !input_good
		&& !hot_unplug_kill |-> gcnt >= 7 * MS_CYC && !outputs_good)
		else $error("main dropped too soon after input loss");
endmodule : pss_seq_sva
bind pss_seq pss_seq_sva #(.MS_CYC(MS_CYC)) i_pss_seq_sva (.sys_clk, .sys_rst,
	.input_in_range, .main_in_regulation, .standby_in_regulation, .hot_unplug_kill,
	.over_current_trip, .over_voltage_trip, .under_voltage_trip, .over_temp_trip,
	.fan_fail, .general_failure, .high_current_warn, .fan_slow_warn, .input_good,
	.outputs_good, .fault_alert_n, .main_output_en, .load_share_connect, .led_amber);

// ### bench/pss_board.sv
`timescale 1ns/1ps
module pss_board
#(
	parameter int RISE = 4
)
(
	// Clock
	input wire logic sys_clk,
	// Bench commands
	input wire logic want_on,
	input wire logic sag,
	// Device pins
	input wire logic main_output_en,
	input wire logic standby_output_en,
	output logic     main_on_request_n,
	output logic     main_in_regulation,
	output logic     standby_in_regulation
);
	int rc = 0;
	// Rail reaches regulation some cycles after enable
	always @(posedge sys_clk)
	begin
		main_on_request_n <= !want_on;
		rc <= main_output_en ? ((rc < RISE) ? rc + 1 : rc) : 0;
	end
	assign main_in_regulation    = (rc == RISE) && !sag;
	assign standby_in_regulation = standby_output_en;
endmodule : pss_board

// ### bench/pss_seq_test.sv
`timescale 1ns/1ps
module pss_seq_test;
	import pss_pkg::*;
	localparam int MS  = 10;
	localparam int LIM = 80000;
	logic              sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic              want_on = 1'b0, sag = 1'b0, hot_unplug_kill = 1'b0;
	logic              input_in_range = 1'b0, standby_trip = 1'b0;
	logic              fan_at_full = 1'b0, share_is_master = 1'b0;
	logic [2:0]        wn = 3'h0;
	logic [5:0]        sd = 6'h00;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata;
	logic [TEMP_W-1:0] inlet_temp = 8'h40;
	logic [TRIM_W-1:0] share_trim_req_mv = 9'h12C, share_trim_mv;
	logic              main_on_request_n, input_good, outputs_good, fault_alert_n;
	logic              present_n, main_in_regulation, standby_in_regulation;
	logic              main_output_en, standby_output_en, fan_full_cmd;
	logic              load_share_connect, led_green, led_amber;
	int                miscompares = 0, checks = 0, cyc = 0, n, i;
	pss_board i_pss_board (.sys_clk, .want_on, .sag, .main_output_en, .standby_output_en,
		.main_on_request_n, .main_in_regulation, .standby_in_regulation);
	pss_seq #(.MS_CYC(MS)) i_pss_seq (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .main_on_request_n, .hot_unplug_kill, .input_good,
		.outputs_good, .fault_alert_n, .present_n, .input_in_range, .main_in_regulation,
		.standby_in_regulation, .standby_trip, .main_output_en, .standby_output_en,
		.over_current_trip(sd[0]), .over_voltage_trip(sd[1]), .under_voltage_trip(sd[2]),
		.over_temp_trip(sd[3]), .fan_fail(sd[4]), .general_failure(sd[5]), .inlet_temp,
		.hotspot_temp_warn(wn[2]), .high_current_warn(wn[1]), .fan_slow_warn(wn[0]),
		.fan_at_full, .fan_full_cmd, .share_is_master, .share_trim_req_mv,
		.load_share_connect, .share_trim_mv, .led_green, .led_amber);
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == LIM)
		begin
			miscompares++;
			tally_and_finish();
		end
	end
	task tally_and_finish();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task cy(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : cy
	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rdc
	// Bounded wait; n holds the cycles taken
	task automatic wt(ref logic s, input logic v);
		n = 0;
		while (s !== v && n < 30000)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
	endtask : wt
	task inr(input int lo, input int hi);
		chk(n >= lo && n <= hi, 1'b1);
	endtask : inr
	initial
	begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		cy(1);
		chk({present_n, fault_alert_n, led_green, led_amber}, 4'h4);
		rdc(REG_CTRL, 32'h0);
		wr(REG_TEMP, 32'hFFFF_FFFF);
		rdc(REG_TEMP, 32'h40);
		rdc(4'h2, 32'h0);
		@(posedge sys_clk);
		input_in_range <= 1'b1;
		wt(input_good, 1'b1);
		inr(999 * MS, 1700 * MS);
		wt(led_green, !led_green);
		wt(led_green, !led_green);
		inr(499 * MS, 501 * MS);
		@(posedge sys_clk);
		want_on <= 1'b1;
		wt(main_output_en, 1'b1);
		inr(5 * MS, 400 * MS);
		cy(2);
		chk({load_share_connect, share_trim_mv}, {1'b1, 9'h0FA});
		wt(outputs_good, 1'b1);
		inr(100 * MS, 500 * MS);
		cy(2);
		chk({led_green, led_amber}, 2'b10);
		@(posedge sys_clk);
		share_trim_req_mv <= 9'h064;
		cy(3);
		chk(share_trim_mv, 9'h064);
		@(posedge sys_clk);
		share_is_master <= 1'b1;
		cy(4);
		chk(share_trim_mv, 9'h000);
		@(posedge sys_clk);
		sag <= 1'b1;
		cy(3);
		chk(outputs_good, 1'b0);
		@(posedge sys_clk);
		sag <= 1'b0;
		fan_at_full <= 1'b1;
		for (i = 0; i < 3; i++)
		begin
			@(posedge sys_clk);
			wn <= 3'h1 << i;
			cy(3);
			chk(fault_alert_n, 1'b0);
		end
		@(posedge sys_clk);
		wn <= 3'h1;
		wt(led_amber, !led_amber);
		wt(led_amber, !led_amber);
		inr(499 * MS, 501 * MS);
		chk({led_green, main_output_en}, 2'b01);
		wr(REG_CTRL, 32'h1);
		cy(3);
		chk(led_green, 1'b0);
		@(posedge sys_clk);
		wn <= 3'h0;
		wt(led_green, !led_green);
		wt(led_green, !led_green);
		inr(249 * MS, 251 * MS);
		for (i = 0; i < 2; i++)
		begin
			wr(REG_CTRL, 32'(i) << 1);
			@(posedge sys_clk);
			inlet_temp <= (i != 0) ? 8'h7B : 8'h72;
			fan_at_full <= 1'b0;
			cy(3);
			chk(fault_alert_n, 1'b1);
			@(posedge sys_clk);
			inlet_temp <= inlet_temp + 8'h01;
			cy(3);
			chk({fan_full_cmd, fault_alert_n}, 2'b11);
			@(posedge sys_clk);
			fan_at_full <= 1'b1;
			cy(3);
			chk(fault_alert_n, 1'b0);
		end
		@(posedge sys_clk);
		inlet_temp <= 8'h40;
		wr(REG_CTRL, 32'h0);
		for (i = 0; i < 6; i++)
		begin
			@(posedge sys_clk);
			sd <= 6'h01 << i;
			@(posedge sys_clk);
			sd <= 6'h00;
			cy(2);
			chk({fault_alert_n, led_green, led_amber}, 3'b001);
			chk({main_output_en, load_share_connect}, 2'b00);
			rdc(REG_EVENTS, 32'h1 << i);
			@(posedge sys_clk);
			want_on <= 1'b0;
			cy(3);
			want_on <= 1'b1;
			cy(4);
			chk(fault_alert_n, 1'b1);
		end
		wt(main_output_en, 1'b1);
		@(posedge sys_clk);
		input_in_range <= 1'b0;
		cy(2);
		chk({input_good, outputs_good, main_output_en}, 3'b001);
		chk({led_green, led_amber}, 2'b00);
		wt(main_output_en, 1'b0);
		inr(7 * MS, 100 * MS);
		@(posedge sys_clk);
		input_in_range <= 1'b1;
		wt(input_good, 1'b1);
		inr(1, 100 * MS);
		wt(main_output_en, 1'b1);
		@(posedge sys_clk);
		want_on <= 1'b0;
		wt(main_output_en, 1'b0);
		inr(1, 100 * MS);
		@(posedge sys_clk);
		want_on <= 1'b1;
		wt(main_output_en, 1'b1);
		@(posedge sys_clk);
		hot_unplug_kill <= 1'b1;
		cy(2);
		chk({main_output_en, standby_output_en}, 2'b01);
		@(posedge sys_clk);
		standby_trip <= 1'b1;
		cy(2);
		chk(standby_output_en, 1'b0);
		@(posedge sys_clk);
		standby_trip <= 1'b0;
		wt(standby_output_en, 1'b1);
		inr(500 * MS, 501 * MS);
		tally_and_finish();
	end
endmodule : pss_seq_test
